// *** verilog/ccsl_top.sv ***
// Command decoding and status reporting logic of a CAN controller.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ccsl_defs.svh"
module ccsl_top (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [7:0]             rdata,
    // Protocol engine side
    input  ccsl_pkg::ccsl_eng_t    eng,
    output ccsl_pkg::ccsl_ord_t    ord
);

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    ccsl_pkg::ccsl_cmd_t    cmd;
    ccsl_pkg::ccsl_tx_state_t tx_state;
    logic [7:0]             warning_limit_setting;
    logic                   send_request;
    logic                   sending_flag;
    logic                   send_done_flag;
    logic                   overrun_flag;
    logic                   receiving_flag;
    logic                   bus_off_flag;
    logic                   error_warning_flag;
    logic [`CCSL_QUEUE_CNT_W-1:0] msg_count;
    logic                   wr_cmd;
    logic                   single_shot_order;
    logic                   loopback_order;
    logic                   tx_irq;
    logic                   rx_irq;
    logic                   overrun_irq;

    assign wr_cmd = wr && (addr == `CCSL_OFS_COMMAND);

    // Each order bit lives in a flop of its own; the struct only gathers them,
    // so no packed variable is written from more than one process.
    assign ord = {send_request, single_shot_order, loopback_order,
                  tx_irq, rx_irq, overrun_irq};

    ccsl_cmd_decode u_dec (
        .clk   (clk),
        .rst_n (rst_n),
        .wr_cmd(wr_cmd),
        .wdata (wdata),
        .cmd   (cmd)
    );

    // ------------------------------------------------------------------------
    // Warning limit register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warning_limit_setting <= `CCSL_WARN_LIMIT_RST;
        end else if (wr && addr == `CCSL_OFS_WARN_LIMIT) begin
            warning_limit_setting <= wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------------------
    // A request held in PENDING stays until cancel or until the engine
    // starts; zeros written to the send bit never reach this machine.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= ccsl_pkg::CCSL_IDLE;
        end else begin
            case (tx_state)
                ccsl_pkg::CCSL_IDLE: begin
                    if (cmd.send) begin
                        tx_state <= ccsl_pkg::CCSL_PENDING;
                    end
                end
                ccsl_pkg::CCSL_PENDING: begin
                    if (eng.tx_started) begin
                        tx_state <= ccsl_pkg::CCSL_SENDING;
                    end else if (cmd.cancel) begin
                        tx_state <= ccsl_pkg::CCSL_IDLE;
                    end
                end
                ccsl_pkg::CCSL_SENDING: begin
                    // A running frame finishes; cancel counts only in the cycle of tx_failed, where it stops the retry.
                    if (eng.tx_ok || (eng.tx_failed && (single_shot_order || cmd.cancel))) begin
                        tx_state <= ccsl_pkg::CCSL_GAP;
                    end else if (eng.tx_failed) begin
                        tx_state <= ccsl_pkg::CCSL_PENDING;
                    end
                end
                ccsl_pkg::CCSL_GAP: begin
                    tx_state <= ccsl_pkg::CCSL_IDLE;
                end
                default: begin
                    tx_state <= ccsl_pkg::CCSL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            send_request <= 1'b0;
        end else begin
            // The held request drops the moment sending begins. It is also the
            // start order seen by the engine.
            send_request <= (tx_state == ccsl_pkg::CCSL_PENDING) && !eng.tx_started;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sending_flag <= 1'b0;
        end else begin
            sending_flag <= (tx_state == ccsl_pkg::CCSL_SENDING);
        end
    end

    // Orders to the engine.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_shot_order <= 1'b0;
            loopback_order    <= 1'b0;
        end else begin
            if (tx_state == ccsl_pkg::CCSL_IDLE && cmd.send) begin
                single_shot_order <= cmd.single_shot;
                loopback_order    <= cmd.loopback;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Completion flag
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            send_done_flag <= 1'b1;
        end else if (cmd.send && tx_state == ccsl_pkg::CCSL_IDLE) begin
            send_done_flag <= 1'b0;
        end else if (tx_state == ccsl_pkg::CCSL_SENDING && eng.tx_ok) begin
            send_done_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Transmit interrupt
    // ------------------------------------------------------------------------
    // Raised whenever the buffer returns to free, aborted or not; a loopback
    // success also sees rx_irq from the stored copy.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_irq <= 1'b0;
        end else begin
            tx_irq <= (tx_state == ccsl_pkg::CCSL_GAP) ||
                      (tx_state == ccsl_pkg::CCSL_PENDING && cmd.cancel &&
                       !eng.tx_started);
        end
    end

    // ------------------------------------------------------------------------
    // Receive queue accounting
    // ------------------------------------------------------------------------
    // Counter saturates; a store into a full count is reported as overrun
    // by the engine, so no wrap can happen.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_count <= '0;
        end else begin
            case ({eng.rx_stored, cmd.slot_free && msg_count != '0})
                2'b10: msg_count <= (&msg_count) ? msg_count
                                                  : msg_count + `CCSL_QUEUE_CNT_W'(1);
                2'b01: msg_count <= msg_count - `CCSL_QUEUE_CNT_W'(1);
                default: msg_count <= msg_count;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_irq <= 1'b0;
        end else if (eng.rx_stored) begin
            rx_irq <= 1'b1;
        end else if (cmd.slot_free && msg_count <= `CCSL_QUEUE_CNT_W'(1)) begin
            rx_irq <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Overrun flag and interrupt
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_flag <= 1'b0;
        end else if (eng.rx_overrun) begin
            overrun_flag <= 1'b1;
        end else if (cmd.overrun_clear) begin
            overrun_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_irq <= 1'b0;
        end else begin
            // Only the first overrun after a clear is signalled.
            overrun_irq <= eng.rx_overrun && (!overrun_flag || cmd.overrun_clear);
        end
    end

    // ------------------------------------------------------------------------
    // Bus state flags
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_off_flag       <= 1'b0;
            error_warning_flag <= 1'b0;
            receiving_flag     <= 1'b0;
        end else begin
            bus_off_flag       <= eng.bus_off;
            error_warning_flag <= (eng.tx_err_count >= warning_limit_setting) ||
                                  (eng.rx_err_count >= warning_limit_setting);
            receiving_flag     <= eng.rx_active;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Writes to the status offset hit no storage at all.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `CCSL_OFS_STATUS: begin
                    rdata <= {bus_off_flag, error_warning_flag, sending_flag,
                              receiving_flag, send_done_flag,
                              (tx_state == ccsl_pkg::CCSL_IDLE),
                              overrun_flag, (msg_count != '0)};
                end
                `CCSL_OFS_WARN_LIMIT: begin
                    rdata <= warning_limit_setting;
                end
                default: begin
                    rdata <= 8'h00;
                end
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

// *** common/ccsl_defs.svh ***
// Offsets, field positions, reset values and timing counts of the command and status logic.
// Behaviour
// - Command register is write-only; reads of it return zero.
// - Loopback send transmits and receives own message; both interrupts mark success.
// - Send request with cancel together sends once, no retry on error or loss.
// - Loopback send with cancel together is a single-shot loopback send.
// - Send, cancel and loopback together act as single-shot normal send.
// - Send and loopback together ignore loopback; a normal send results.
// - Held send request clears when the engine reports the start, one cycle before the sending flag sets.
// - Writing one to overrun clear clears overrun flag; zero does nothing.
// - While overrun flag stays set no further overrun interrupt is raised.
// - Slot free releases current message; empty queue clears receive interrupt.
// - Cancel drops a pending request; a started frame completes.
// - Transmit interrupt is raised even for an aborted message.
// - Writing zero to send request does not cancel an earlier request.
// - Status register is read-only; writes to it have no effect.
// - Status bit 7 shows bus-off.
// - Status bit 6 shows an error counter at or above the warning limit.
// - Status bit 5 shows transmitting, bit 4 shows receiving.
// - Status bit 3 shows last requested send completed.
// - Status bit 2 shows transmit buffer free for host writes.
// - Done flag clears on a send request accepted in idle and stays clear until success.
// - Status bit 1 shows overrun, bit 0 shows a message held.
`ifndef CCSL_DEFS_SVH
`define CCSL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CCSL_ADDR_W          8
`define CCSL_OFS_COMMAND     8'h01
`define CCSL_OFS_STATUS      8'h02
`define CCSL_OFS_WARN_LIMIT  8'h0d

// ----------------------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------------------
`define CCSL_CMD_SEND        0
`define CCSL_CMD_CANCEL      1
`define CCSL_CMD_SLOT_FREE   2
`define CCSL_CMD_OVR_CLEAR   3
`define CCSL_CMD_LOOPBACK    4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define CCSL_WARN_LIMIT_RST  8'h60
`define CCSL_CMD_GAP_CYCLES  2'h2
`define CCSL_QUEUE_CNT_W     4

`endif

// *** common/ccsl_pkg.sv ***
// Types shared by the command and status logic.
package ccsl_pkg;

    // Decoded one-cycle command pulses.
    typedef struct packed {
        logic loopback;
        logic overrun_clear;
        logic slot_free;
        logic cancel;
        logic send;
        logic single_shot;
    } ccsl_cmd_t;

    // Events reported by the protocol engine.
    typedef struct packed {
        logic bus_off;
        logic tx_started;
        logic tx_ok;
        logic tx_failed;
        logic rx_active;
        logic rx_stored;
        logic rx_overrun;
        logic [7:0] tx_err_count;
        logic [7:0] rx_err_count;
    } ccsl_eng_t;

    // Orders towards the protocol engine and interrupt flags.
    typedef struct packed {
        logic start;
        logic single_shot;
        logic loopback;
        logic tx_irq;
        logic rx_irq;
        logic overrun_irq;
    } ccsl_ord_t;

    typedef enum logic [3:0] {
        CCSL_IDLE    = 4'b0001,
        CCSL_PENDING = 4'b0010,
        CCSL_SENDING = 4'b0100,
        CCSL_GAP     = 4'b1000
    } ccsl_tx_state_t;

endpackage

// *** verilog/ccsl_cmd_decode.sv ***
// Decoder that turns a command write into one-cycle command pulses.
`timescale 1ns/1ps
`include "ccsl_defs.svh"
module ccsl_cmd_decode (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Write side
    input  wire logic              wr_cmd,
    input  wire logic [7:0]        wdata,
    // Decoded pulses
    output ccsl_pkg::ccsl_cmd_t    cmd
);

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    // Bits 7 to 5 are never looked at, so they cannot start anything.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= '0;
        end else if (wr_cmd) begin
            cmd.send          <= wdata[`CCSL_CMD_SEND] | wdata[`CCSL_CMD_LOOPBACK];
            // Loopback only when send is absent.
            cmd.loopback      <= wdata[`CCSL_CMD_LOOPBACK] & ~wdata[`CCSL_CMD_SEND];
            // Cancel with a request means one try only.
            cmd.single_shot   <= wdata[`CCSL_CMD_CANCEL] &
                                 (wdata[`CCSL_CMD_SEND] | wdata[`CCSL_CMD_LOOPBACK]);
            cmd.cancel        <= wdata[`CCSL_CMD_CANCEL] &
                                 ~(wdata[`CCSL_CMD_SEND] | wdata[`CCSL_CMD_LOOPBACK]);
            cmd.slot_free     <= wdata[`CCSL_CMD_SLOT_FREE];
            cmd.overrun_clear <= wdata[`CCSL_CMD_OVR_CLEAR];
        end else begin
            cmd <= '0;
        end
    end

endmodule

// *** verif/ccsl_eng_model.sv ***
// Behavioural protocol engine and bus that answer the command and status logic.
`timescale 1ns/1ps
module ccsl_eng_model (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Controller side
    input  ccsl_pkg::ccsl_ord_t ord,
    output ccsl_pkg::ccsl_eng_t eng
);
    int   start_delay = 2;
    int   fail_count  = 0;
    logic lb;

    initial eng = '0;

    // A frame launches only if the request still stands after the bus wait.
    always begin
        @(posedge clk);
        if (rst_n && ord.start) begin
            repeat (start_delay) @(posedge clk);
            if (ord.start) begin
                lb = ord.loopback;
                eng.tx_started <= 1'b1;
                @(posedge clk);
                eng.tx_started <= 1'b0;
                eng.rx_active <= lb;
                repeat (4) @(posedge clk);
                eng.tx_ok <= (fail_count == 0);
                eng.tx_failed <= (fail_count != 0);
                eng.rx_stored <= lb && (fail_count == 0);
                eng.rx_active <= 1'b0;
                @(posedge clk);
                if (fail_count > 0) fail_count--;
                {eng.tx_ok, eng.tx_failed, eng.rx_stored} <= 3'h0;
            end
        end
    end

    task automatic rx_msg(input logic ovr);
        eng.rx_active <= 1'b1;
        repeat (3) @(posedge clk);
        eng.rx_active <= 1'b0;
        eng.rx_overrun <= ovr;
        eng.rx_stored <= !ovr;
        @(posedge clk);
        eng.rx_overrun <= 1'b0;
        eng.rx_stored <= 1'b0;
    endtask

    task automatic set_err(input logic bo, ra, input logic [7:0] te, re);
        eng.bus_off <= bo;
        eng.rx_active <= ra;
        eng.tx_err_count <= te;
        eng.rx_err_count <= re;
    endtask
endmodule

// *** verif/ccsl_top_props.sv ***
// Concurrent checks on the ports of the command and status logic.
`timescale 1ns/1ps
module ccsl_top_props (
    // Clock and reset
    input wire logic           clk,
    input wire logic           rst_n,
    // Register port
    input wire logic [7:0]     addr,
    input wire logic [7:0]     wdata,
    input wire logic           wr,
    input wire logic           rd,
    input wire logic [7:0]     rdata,
    // Protocol engine side
    input ccsl_pkg::ccsl_eng_t eng,
    input ccsl_pkg::ccsl_ord_t ord
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic cw;
    logic ovr_lock;
    assign cw = wr && addr == 8'h01;

    // The lock drops on the clear write itself, early, which only loosens the check.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_lock <= 1'b0;
        end else if (cw && wdata[3]) begin
            ovr_lock <= 1'b0;
        end else if (ord.overrun_irq) begin
            ovr_lock <= 1'b1;
        end
    end

    property p_cmd_read; rd && addr == 8'h01 |=> rdata == 8'h00; endproperty
    a_cmd_read: assert property (p_cmd_read) else $error("command read not zero");
    property p_start_clr; eng.tx_started && ord.start |=> !ord.start; endproperty
    a_start_clr: assert property (p_start_clr) else $error("request held on start");
    property p_keep; ord.start && !eng.tx_started && !$past(cw && wdata[1])
        && !$past(cw && wdata[1], 2) && !$past(cw && wdata[1], 3) |=> ord.start; endproperty
    a_keep: assert property (p_keep) else $error("request dropped");
    property p_abort_irq; cw && wdata[1] && ord.start ##1 (ord.start && !eng.tx_started) [*2]
        |-> ##[0:4] ord.tx_irq; endproperty
    a_abort_irq: assert property (p_abort_irq) else $error("no transmit irq");
    property p_ovr; eng.rx_overrun && ovr_lock |=> !ord.overrun_irq [*3]; endproperty
    a_ovr: assert property (p_ovr) else $error("repeated overrun irq");
    property p_rx_fall; $fell(ord.rx_irq) |-> $past(cw && wdata[2], 2)
        || $past(cw && wdata[2], 3) || $past(cw && wdata[2], 4); endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("rx irq fell alone");
    property p_single; cw && wdata[1:0] == 2'b11 && !ord.start
        |-> ##3 (ord.start && ord.single_shot && !ord.loopback); endproperty
    a_single: assert property (p_single) else $error("single shot wrong");
    property p_loop_ss; cw && wdata[4] && wdata[1:0] == 2'b10 && !ord.start
        |-> ##3 (ord.start && ord.single_shot && ord.loopback); endproperty
    a_loop_ss: assert property (p_loop_ss) else $error("loopback single wrong");
    property p_loop_ign; cw && wdata[4] && wdata[1:0] == 2'b01 && !ord.start
        |-> ##3 (ord.start && !ord.single_shot && !ord.loopback); endproperty
    a_loop_ign: assert property (p_loop_ign) else $error("loopback not ignored");
endmodule

bind ccsl_top ccsl_top_props i_props (.clk, .rst_n, .addr, .wdata, .wr, .rd,
    .rdata, .eng, .ord);

// *** verif/tb.sv ***
// Self-checking testbench of the command and status logic.
`timescale 1ns/1ps
module tb;
    logic                clk;
    logic                rst_n;
    logic                wr;
    logic                rd;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic [7:0]          rdata;
    ccsl_pkg::ccsl_eng_t eng;
    ccsl_pkg::ccsl_ord_t ord;
    logic [7:0]          exp_q[$];
    logic                pend = 1'b0;
    int                  fails = 0;
    int                  total_checks = 0;
    int                  ovr_irqs = 0;
    int                  nmsg = 0;
    logic [7:0]          cmds [6] = '{8'h01, 8'h03, 8'h13, 8'h12, 8'h11, 8'h10};
    logic [2:0]          kind [6] = '{3'h1, 3'h5, 3'h4, 3'h6, 3'h0, 3'h2};

    ccsl_top i_dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .eng, .ord);
    ccsl_eng_model i_eng (.clk, .rst_n, .ord, .eng);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk) begin
        if (pend) check(rdata, exp_q.pop_front());
        pend = rd;
        if (ord.overrun_irq === 1'b1) ovr_irqs++;
    end

    task automatic wr_reg(input logic [7:0] a, d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return eng.tx_started;
            1: return ord.tx_irq;
            default: return eng.tx_failed;
        endcase
    endfunction

    task automatic wait_on(input int k);
        int n;
        n = 0;
        while (sig(k) !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check(n < 200, 1'b1);
    endtask

    task automatic lvl(input logic bo, ra, input logic [7:0] te, re, e);
        i_eng.set_err(bo, ra, te, re);
        repeat (3) @(posedge clk);
        rd_reg(8'h02, e);
    endtask

    task automatic close_out();
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] r;
        void'($urandom(7024));
        {rst_n, wr, rd, addr, wdata} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(8'h02, 8'h0c);
        rd_reg(8'h01, 8'h00);
        wr_reg(8'h02, 8'hff);
        rd_reg(8'h02, 8'h0c);
        rd_reg(8'h7f, 8'h00);
        for (int i = 0; i < 6; i++) begin
            i_eng.start_delay = $urandom_range(5, 2);
            i_eng.fail_count = kind[i][0];
            wr_reg(8'h01, cmds[i] | {3'($urandom_range(7, 0)), 5'h00});
            repeat (2) @(posedge clk);
            check({6'h00, ord.single_shot, ord.loopback}, {6'h00, kind[i][2:1]});
            rd_reg(8'h02, {7'h00, nmsg != 0});
            if (kind[i] == 3'h5) begin
                wait_on(2);
                repeat (8) @(posedge clk);
            end else begin
                wait_on(1);
            end
            nmsg += kind[i][1];
            rd_reg(8'h02, {4'h0, kind[i] != 3'h5, 2'b10, nmsg != 0});
            check(ord.rx_irq, nmsg != 0);
        end
        i_eng.start_delay = 30;
        wr_reg(8'h01, 8'h01);
        wr_reg(8'h01, 8'h00);
        check(ord.start, 1'b1);
        wr_reg(8'h01, 8'h02);
        wait_on(1);
        rd_reg(8'h02, 8'h05);
        i_eng.start_delay = 2;
        wr_reg(8'h01, 8'h01);
        wait_on(0);
        @(posedge clk);
        rd_reg(8'h02, 8'h21);
        wr_reg(8'h01, 8'h02);
        wait_on(1);
        rd_reg(8'h02, 8'h0d);
        i_eng.rx_msg(1'b0);
        for (int i = 0; i < 3; i++) begin
            check(ord.rx_irq, 1'b1);
            wr_reg(8'h01, 8'h04);
        end
        repeat (2) @(posedge clk);
        check(ord.rx_irq, 1'b0);
        i_eng.rx_msg(1'b1);
        i_eng.rx_msg(1'b1);
        repeat (3) @(posedge clk);
        check(8'(ovr_irqs), 8'h01);
        rd_reg(8'h02, 8'h0e);
        wr_reg(8'h01, 8'h00);
        rd_reg(8'h02, 8'h0e);
        wr_reg(8'h01, 8'h08);
        rd_reg(8'h02, 8'h0c);
        i_eng.rx_msg(1'b1);
        repeat (3) @(posedge clk);
        check(8'(ovr_irqs), 8'h02);
        wr_reg(8'h01, 8'h08);
        r = 8'($urandom_range(8'h5f, 0));
        lvl(1'b1, 1'b0, 8'h60, r, 8'hcc);
        lvl(1'b0, 1'b1, r, 8'h60, 8'h5c);
        lvl(1'b0, 1'b0, 8'h5f, r, 8'h0c);
        close_out();
    end

    // Cuts a hang short well beyond the few hundred cycles the sequence needs.
    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule
